// file: tso_consts.svh
/*
 Timing counts, field positions and framing figures of the stream output.
 Assumes mclk runs at 10 MHz; included by the design and the bench.
*/
`ifndef TSO_CONSTS_SVH
`define TSO_CONSTS_SVH
`define TSO_MCLK_HZ 10000000
`define TSO_MCLK_NS 100
`define TSO_LINK_PERIOD_NS 800
`define TSO_LINK_HALF ((`TSO_LINK_PERIOD_NS / `TSO_MCLK_NS) / 2)
`define TSO_TONE_HZ 22000
`define TSO_TONE_HALF (`TSO_MCLK_HZ / (2 * `TSO_TONE_HZ))
`define TSO_BLOCK_LEN 204
`define TSO_PAYLOAD_LEN 188
`define TSO_TEI_SLOT 1
`define TSO_TEI_BIT 7
`define TSO_TEST_ADDR 8'h14
`define TSO_FORMAT_ADDR 8'h18
`define TSO_REGULATE_BIT 5
`define TSO_SERIAL_VALID_BIT 6
`define TSO_SERIAL_BIT 0
`define TSO_FIFO_DEPTH 2
`define TSO_ENTRY_W 10
`endif

// file: tso_pkg.sv
/*
 Types shared by the stream output block.
 Assumes tso_consts.svh is on the include path.
*/
package tso_pkg;
   typedef enum logic [2:0] {
      SLOT_IDLE = 3'h1,
      SLOT_PAYLOAD = 3'h2,
      SLOT_PARITY = 3'h4
   } tso_slot_t;
endpackage

// file: tso_output_status.sv
/*
 Transport stream output framer with lock, test and control outputs.
 Assumes upstream bytes of 204-byte corrected blocks arrive on mclk with
 a first-byte mark; config ports are held by host registers elsewhere.
*/
`include "tso_consts.svh"

// Behaviour
// RQ1: Low reset initialises all internal state.
// RQ2: Reset leaves host configuration inputs untouched.
// RQ3: Reset acts asynchronously to mclk.
// RQ4: Selectable capture edge of stream clock.
// RQ5: Stream clock toggles through redundancy slots.
// RQ6: Valid only on payload bytes.
// RQ7: Frame start marks first block byte.
// RQ8: Strobe rises for each new payload byte.
// RQ9: Strobe silent during redundancy bytes.
// RQ10: Frame error flags uncorrectable blocks.
// RQ11: Uncorrectable block sets stream error flag.
// RQ12: Demodulator lock output follows carrier lock.
// RQ13: Node sync output follows decoder sync.
// RQ14: Overall lock needs all stages and data.
// RQ15: Symbol tick pulses once per symbol; a sym_count of 3 gives a one-cycle tick only.
// RQ16: Two symbols give two-cycle tick.
// RQ17: Raw serial taken before polarity correction.
// RQ18: Raw clock rising edge marks valid bit.
// RQ19: Sigma-delta one-bit DAC, 8-bit value.
// RQ20: Digital 22 kHz antenna tone.
// RQ21: Test outputs selected by test register.
// RQ22: Gain control as one-bit density stream.
// RQ23: Regulated mode runs from internal buffer.
// RQ24: Serial-valid bit picks regulated strobe style.
// RQ25: Format bit selects serial or parallel.
// RQ26: Block is 188 payload then 16 parity.
module tso_output_status (
   input wire logic mclk,
   input wire logic nrst,
   input wire logic cfg_edge_falling,
   input wire logic [7:0] test_ctrl,
   input wire logic [7:0] format_ctrl,
   input wire logic [7:0] dac_level,
   input wire logic [7:0] agc_level,
   input wire logic tone_enable,
   input wire logic [7:0] in_byte,
   input wire logic in_first,
   input wire logic in_uncorrectable,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic rx_ready_pin,
   input wire logic demod_lock_in,
   input wire logic node_sync_in,
   input wire logic byte_sync_in,
   input wire logic rs_sync_in,
   input wire logic [1:0] sym_count,
   input wire logic dec_bit,
   input wire logic dec_bit_valid,
   output logic stream_clk,
   output logic [7:0] stream_data,
   output logic stream_valid,
   output logic frame_start,
   output logic byte_strobe,
   output logic frame_error,
   output logic demod_phase_locked,
   output logic decoder_node_synced,
   output logic overall_lock,
   output logic symbol_tick,
   output logic raw_serial_out,
   output logic raw_serial_clock,
   output logic aux_one_bit_dac,
   output logic gain_control_bitstream,
   output logic antenna_tone_out,
   output logic [15:0] test_out
);
   localparam logic [2:0] LINK_LAST = 3'(`TSO_LINK_HALF - 1);
   localparam logic [7:0] TONE_LAST = 8'(`TSO_TONE_HALF - 1);
   localparam logic [7:0] SLOT_LAST = 8'(`TSO_BLOCK_LEN - 1);
   localparam logic [7:0] PAY_LEN = 8'(`TSO_PAYLOAD_LEN);
   localparam logic [7:0] TEI_SLOT = 8'(`TSO_TEI_SLOT);

   function automatic logic [8:0] sd_step(input logic [7:0] acc,
                                          input logic [7:0] lvl);
      sd_step = {1'b0, acc} + {1'b0, lvl};
   endfunction

   logic [2:0] ph_reg;
   logic clk_reg;
   logic rx_s1_reg;
   logic rx_s2_reg;
   logic [`TSO_ENTRY_W-1:0] mem_reg [0:`TSO_FIFO_DEPTH-1];
   logic wr_ptr_reg;
   logic rd_ptr_reg;
   logic [1:0] cnt_reg;
   logic [7:0] slot_reg;
   logic [7:0] sh_reg;
   logic [2:0] bit_reg;
   tso_pkg::tso_slot_t kind_reg;
   logic [7:0] data_reg;
   logic valid_reg;
   logic start_reg;
   logic strobe_reg;
   logic err_reg;
   logic seen_reg;
   logic demod_reg;
   logic node_reg;
   logic lock_reg;
   logic pend_reg;
   logic tick_reg;
   logic raw_reg;
   logic rclk_reg;
   logic hold_v_reg;
   logic hold_b_reg;
   logic [7:0] dac_acc_reg;
   logic dac_reg;
   logic [7:0] agc_acc_reg;
   logic agc_reg;
   logic [7:0] tone_cnt_reg;
   logic tone_reg;
   logic [15:0] test_reg;

   wire tick = (ph_reg == LINK_LAST);
   // Data launches on the edge opposite the one the receiver captures on.
   wire launch = tick && ((~clk_reg) == cfg_edge_falling); // see RQ4
   wire capture = tick && !launch;
   // Config bits come straight from host registers, which reset never clears.
   wire ser = format_ctrl[`TSO_SERIAL_BIT]; // see RQ25, see RQ2
   wire regm = test_ctrl[`TSO_REGULATE_BIT]; // see RQ23
   wire sval = test_ctrl[`TSO_SERIAL_VALID_BIT]; // see RQ24
   wire load = launch && (!ser || bit_reg == 3'h0);
   wire nonempty = (cnt_reg != 2'h0);
   wire pop = load && nonempty && rx_s2_reg;
   wire push = in_valid && in_ready;
   wire [`TSO_ENTRY_W-1:0] head = mem_reg[rd_ptr_reg];
   wire head_first = head[8];
   wire head_err = head[9];
   wire [7:0] slot_inc = (slot_reg == SLOT_LAST) ? 8'h00 : slot_reg + 8'h01;
   wire [7:0] slot_n = head_first ? 8'h00 : slot_inc; // see RQ26
   wire blk_err = head_first ? head_err : err_reg;
   wire tei = blk_err && (slot_n == TEI_SLOT); // see RQ11
   wire [7:0] byte_val = {head[7] | tei, head[6:0]};
   wire is_pay = (slot_n < PAY_LEN); // see RQ6
   wire [7:0] cur = load ? byte_val : {sh_reg[6:0], 1'b0};
   wire kind_pay = (kind_reg == tso_pkg::SLOT_PAYLOAD);
   wire all_sync = demod_lock_in && node_sync_in && byte_sync_in
                   && rs_sync_in;
   wire [8:0] dac_sum = sd_step(dac_acc_reg, dac_level);
   wire [8:0] agc_sum = sd_step(agc_acc_reg, agc_level);
   wire [15:0] test_sel =
      (test_ctrl[1:0] == 2'h0) ? {data_reg, valid_reg, start_reg,
                                  strobe_reg, err_reg, clk_reg, demod_reg,
                                  node_reg, lock_reg} :
      (test_ctrl[1:0] == 2'h1) ? {slot_reg, cnt_reg, bit_reg, rx_s2_reg,
                                  in_ready, push} :
      (test_ctrl[1:0] == 2'h2) ? {8'h00, tick_reg, raw_reg, rclk_reg,
                                  dac_reg, agc_reg, tone_reg, pop, load} :
      16'h0000;

   assign in_ready = (cnt_reg != 2'h2);
   assign stream_clk = clk_reg;
   assign stream_data = data_reg;
   assign stream_valid = valid_reg;
   assign frame_start = start_reg;
   assign byte_strobe = strobe_reg;
   assign frame_error = err_reg;
   assign demod_phase_locked = demod_reg;
   assign decoder_node_synced = node_reg;
   assign overall_lock = lock_reg;
   assign symbol_tick = tick_reg;
   assign raw_serial_out = raw_reg;
   assign raw_serial_clock = rclk_reg;
   assign aux_one_bit_dac = dac_reg;
   assign gain_control_bitstream = agc_reg;
   assign antenna_tone_out = tone_reg;
   assign test_out = test_reg;

   // The divider runs free so the stream clock never stops, even in gaps.
   always_ff @(posedge mclk or negedge nrst) begin // see RQ1, see RQ3
      if (!nrst) begin
         ph_reg <= 3'h0;
         clk_reg <= 1'b0;
      end else begin
         ph_reg <= tick ? 3'h0 : ph_reg + 3'h1;
         if (tick) begin
            clk_reg <= ~clk_reg; // see RQ5
         end
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         rx_s1_reg <= 1'b0;
         rx_s2_reg <= 1'b0;
      end else begin
         rx_s1_reg <= rx_ready_pin;
         rx_s2_reg <= rx_s1_reg;
      end
   end

   // Two entries absorb one stalled slot; beyond that in_ready holds upstream.
   always_ff @(posedge mclk or negedge nrst) begin // see RQ23
      if (!nrst) begin
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
         cnt_reg <= 2'h0;
         mem_reg[0] <= 10'h000;
         mem_reg[1] <= 10'h000;
      end else begin
         if (push) begin
            mem_reg[wr_ptr_reg] <= {in_uncorrectable, in_first, in_byte};
            wr_ptr_reg <= ~wr_ptr_reg;
         end
         if (pop) begin
            rd_ptr_reg <= ~rd_ptr_reg;
         end
         cnt_reg <= cnt_reg + {1'b0, push} - {1'b0, pop};
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         slot_reg <= SLOT_LAST;
         kind_reg <= tso_pkg::SLOT_IDLE;
         err_reg <= 1'b0;
         valid_reg <= 1'b0;
         start_reg <= 1'b0;
      end else if (load) begin
         if (pop) begin
            slot_reg <= slot_n;
            kind_reg <= is_pay ? tso_pkg::SLOT_PAYLOAD
                               : tso_pkg::SLOT_PARITY; // see RQ26
            err_reg <= blk_err; // see RQ10
         end else begin
            kind_reg <= tso_pkg::SLOT_IDLE;
         end
         valid_reg <= pop && is_pay; // see RQ6
         start_reg <= pop && (slot_n == 8'h00); // see RQ7
      end
   end

   // Serial mode sends MSB first on bit 0 of the data bus.
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         data_reg <= 8'h00;
         sh_reg <= 8'h00;
         bit_reg <= 3'h0;
      end else if (launch) begin
         if (ser) begin
            data_reg <= {7'h00, cur[7]};
            sh_reg <= cur;
            bit_reg <= bit_reg + 3'h1;
         end else begin
            data_reg <= pop ? byte_val : 8'h00;
            bit_reg <= 3'h0;
         end
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         strobe_reg <= 1'b0;
      end else if (ser && regm) begin
         if (load || launch) begin
            if (!sval) begin
               if (launch && (load ? (pop && is_pay) : kind_pay)) begin
                  strobe_reg <= ~strobe_reg; // see RQ24
               end
            end else begin
               strobe_reg <= load ? (pop && is_pay) : kind_pay; // see RQ24
            end
         end
      end else if (launch) begin
         strobe_reg <= 1'b0;
      end else if (capture) begin
         // Rising only after the byte is settled keeps a capture clean.
         strobe_reg <= kind_pay && (!ser || bit_reg == 3'h1); // see RQ8, see RQ9
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         demod_reg <= 1'b0;
         node_reg <= 1'b0;
         lock_reg <= 1'b0;
         seen_reg <= 1'b0;
      end else begin
         demod_reg <= demod_lock_in; // see RQ12
         node_reg <= node_sync_in; // see RQ13
         seen_reg <= all_sync && (seen_reg || (pop && is_pay));
         lock_reg <= all_sync && seen_reg; // see RQ14
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         pend_reg <= 1'b0;
         tick_reg <= 1'b0;
      end else begin
         tick_reg <= (sym_count != 2'h0) || pend_reg; // see RQ15
         pend_reg <= (sym_count == 2'h2); // see RQ16
      end
   end

   // Bits arrive before polarity correction; one bit per two cycles at most.
   always_ff @(posedge mclk or negedge nrst) begin // see RQ17
      if (!nrst) begin
         raw_reg <= 1'b0;
         rclk_reg <= 1'b1;
         hold_v_reg <= 1'b0;
         hold_b_reg <= 1'b0;
      end else if (!rclk_reg) begin
         rclk_reg <= 1'b1; // see RQ18
         hold_v_reg <= dec_bit_valid;
         hold_b_reg <= dec_bit;
      end else if (hold_v_reg || dec_bit_valid) begin
         raw_reg <= hold_v_reg ? hold_b_reg : dec_bit;
         rclk_reg <= 1'b0;
         hold_v_reg <= hold_v_reg && dec_bit_valid;
         hold_b_reg <= dec_bit;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         dac_acc_reg <= 8'h00;
         dac_reg <= 1'b0;
         agc_acc_reg <= 8'h00;
         agc_reg <= 1'b0;
      end else begin
         dac_acc_reg <= dac_sum[7:0];
         dac_reg <= dac_sum[8]; // see RQ19
         agc_acc_reg <= agc_sum[7:0];
         agc_reg <= agc_sum[8]; // see RQ22
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         tone_cnt_reg <= 8'h00;
         tone_reg <= 1'b0;
      end else if (!tone_enable) begin
         tone_cnt_reg <= 8'h00;
         tone_reg <= 1'b0;
      end else begin
         tone_cnt_reg <= (tone_cnt_reg == TONE_LAST) ? 8'h00
                                                     : tone_cnt_reg + 8'h01;
         if (tone_cnt_reg == TONE_LAST) begin
            tone_reg <= ~tone_reg; // see RQ20
         end
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         test_reg <= 16'h0000;
      end else begin
         test_reg <= test_sel; // see RQ21
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   a_clk_half_period: assert property ($rose(stream_clk) |-> // see RQ5
      stream_clk [*4] ##1 !stream_clk)
      else $error("stream clock half period wrong");
   a_valid_payload: assert property (stream_valid |-> // see RQ6
      (slot_reg < PAY_LEN) && kind_pay)
      else $error("valid outside payload");
   a_start_first: assert property (frame_start |-> // see RQ7
      (slot_reg == 8'h00) && stream_valid)
      else $error("frame start not on first byte");
   a_strobe_parity: assert property ( // see RQ9
      kind_reg == tso_pkg::SLOT_PARITY |-> !$rose(byte_strobe))
      else $error("strobe moved in parity slot");
   a_strobe_payload: assert property ( // see RQ8
      (!ser && $rose(byte_strobe)) |-> stream_valid && $past(capture))
      else $error("strobe rose without payload");
   a_tei_flag: assert property ((!ser && stream_valid // see RQ11
      && frame_error && slot_reg == TEI_SLOT && !$rose(start_reg)
      && $changed(slot_reg)) |-> stream_data[`TSO_TEI_BIT])
      else $error("error flag missing in stream");
   a_lock_needs_all: assert property (overall_lock |-> // see RQ14
      $past(all_sync) && $past(seen_reg))
      else $error("lock without all stages");
   a_sym_double: assert property ((sym_count == 2'h2) |=> // see RQ16
      symbol_tick ##1 symbol_tick)
      else $error("double symbol tick short");
   a_sym_single: assert property ( // see RQ15
      (sym_count == 2'h1 && !pend_reg) |=> symbol_tick)
      else $error("symbol tick missing");
   a_raw_edge_stable: assert property ($rose(raw_serial_clock) |-> // see RQ18
      $stable(raw_serial_out) && $past(!raw_serial_clock))
      else $error("raw data moved at clock edge");
   a_tone_period: assert property ($changed(tone_reg) && // see RQ20
      tone_enable && $past(tone_enable) |-> $past(tone_cnt_reg) == TONE_LAST)
      else $error("tone half period wrong");

   c_frame_start: cover property (frame_start);
   c_parity_slot: cover property (kind_reg == tso_pkg::SLOT_PARITY);
   c_stall_full: cover property (!rx_s2_reg && cnt_reg == 2'h2);
   c_serial_strobe: cover property (ser && regm && $rose(byte_strobe));
endmodule

// file: tso_sink.sv
/*
 Receiver model for the stream output: captures bytes and counts strobes.
 Assumes the bench drives stall and reads the counters by hierarchy.
*/
module tso_sink (
   input wire logic stream_clk,
   input wire logic [7:0] stream_data,
   input wire logic stream_valid,
   input wire logic frame_start,
   input wire logic byte_strobe,
   input wire logic frame_error,
   input wire logic cfg_edge_falling,
   input wire logic raw_serial_out,
   input wire logic raw_serial_clock,
   input wire logic stall,
   output logic rx_ready_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] got [0:255];
   int n = 0;
   int strobes = 0;
   int start_idx = -1;
   logic err_at_start = 1'b0;
   logic last_raw = 1'b0;
   // A stalled receiver holds ready low for the whole stall.
   assign rx_ready_pin = !stall;
   // Bytes are taken only on the chosen capture edge.
   always @(stream_clk) begin
      if ((stream_clk ^ cfg_edge_falling) && stream_valid === 1'b1) begin
         if (frame_start === 1'b1) begin
            start_idx = n;
            err_at_start = frame_error;
         end
         got[n[7:0]] = stream_data;
         n++;
      end
   end
   always @(posedge byte_strobe) strobes++;
   // Raw bits are sampled on the rising raw clock.
   always @(posedge raw_serial_clock) last_raw = raw_serial_out;
endmodule

// file: tso_output_status_test.sv
/*
 Self-checking bench for the stream output block with a receiver model.
 Assumes tso_consts.svh is on the include path and mclk is 10 MHz.
*/
`include "tso_consts.svh"
module tso_output_status_test;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic demod;
      logic node;
      logic [1:0] sym;
      logic dbit;
      logic dval;
      logic tick1;
      logic tick2;
      logic rclk1;
      logic raw2;
   } tso_row_t;
   tso_row_t rows [0:3] = '{10'b1001_11_1001, 10'b0110_01_1100,
      10'b1100_10_0010, 10'b0001_11_1001};
   logic mclk = 1'b0, nrst = 1'b0, stall = 1'b1;
   logic cfg_edge_falling = 1'b0, tone_enable = 1'b1;
   logic [7:0] test_ctrl = 8'h00, format_ctrl = 8'h00;
   logic [7:0] dac_level = 8'h40, agc_level = 8'hC0, in_byte = 8'h00;
   logic in_first = 1'b0, in_uncorrectable = 1'b0, in_valid = 1'b0;
   logic demod_lock_in = 1'b0, node_sync_in = 1'b0;
   logic byte_sync_in = 1'b0, rs_sync_in = 1'b0;
   logic [1:0] sym_count = 2'h0;
   logic dec_bit = 1'b0, dec_bit_valid = 1'b0;
   logic in_ready, rx_ready_pin, stream_clk, stream_valid, frame_start;
   logic byte_strobe, frame_error, demod_phase_locked, decoder_node_synced;
   logic overall_lock, symbol_tick, raw_serial_out, raw_serial_clock;
   logic aux_one_bit_dac, gain_control_bitstream, antenna_tone_out;
   logic [7:0] stream_data;
   logic [15:0] test_out;
   int num_errors = 0, compares = 0;
   int i, k, ones_dac, ones_agc, rises, vals, s0;
   logic prev;

   initial begin
      forever #50 mclk = ~mclk;
   end

   tso_output_status u_dut (.mclk(mclk), .nrst(nrst),
      .cfg_edge_falling(cfg_edge_falling), .test_ctrl(test_ctrl),
      .format_ctrl(format_ctrl), .dac_level(dac_level),
      .agc_level(agc_level), .tone_enable(tone_enable), .in_byte(in_byte),
      .in_first(in_first), .in_uncorrectable(in_uncorrectable),
      .in_valid(in_valid), .in_ready(in_ready), .rx_ready_pin(rx_ready_pin),
      .demod_lock_in(demod_lock_in), .node_sync_in(node_sync_in),
      .byte_sync_in(byte_sync_in), .rs_sync_in(rs_sync_in),
      .sym_count(sym_count), .dec_bit(dec_bit),
      .dec_bit_valid(dec_bit_valid), .stream_clk(stream_clk),
      .stream_data(stream_data), .stream_valid(stream_valid),
      .frame_start(frame_start), .byte_strobe(byte_strobe),
      .frame_error(frame_error), .demod_phase_locked(demod_phase_locked),
      .decoder_node_synced(decoder_node_synced),
      .overall_lock(overall_lock), .symbol_tick(symbol_tick),
      .raw_serial_out(raw_serial_out), .raw_serial_clock(raw_serial_clock),
      .aux_one_bit_dac(aux_one_bit_dac),
      .gain_control_bitstream(gain_control_bitstream),
      .antenna_tone_out(antenna_tone_out), .test_out(test_out));

   tso_sink u_sink (.stream_clk(stream_clk), .stream_data(stream_data),
      .stream_valid(stream_valid), .frame_start(frame_start),
      .byte_strobe(byte_strobe), .frame_error(frame_error),
      .cfg_edge_falling(cfg_edge_falling), .raw_serial_out(raw_serial_out),
      .raw_serial_clock(raw_serial_clock), .stall(stall),
      .rx_ready_pin(rx_ready_pin));

   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      compares++;
      if (seen !== want) begin
         num_errors++;
         $display("Error at %0t: seen %0h expected %0h", $time, seen, want);
      end
   endtask

   task automatic print_verdict;
      $display("Comparisons %0d, mismatches %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic timeout;
      num_errors++;
      print_verdict();
   endtask

   // The valid line stays high between bytes; each push sets it again and the caller lowers it after the last.
   task automatic push(input logic [7:0] b, input logic first);
      int j;
      in_byte = b;
      in_first = first;
      in_uncorrectable = first;
      in_valid = 1'b1;
      for (j = 0; j < 4000 && in_ready !== 1'b1; j++) @(negedge mclk);
      if (j == 4000) timeout();
      @(negedge mclk);
   endtask

   initial begin
      repeat (16) @(posedge mclk);
      @(negedge mclk);
      nrst = 1'b1;
      @(negedge mclk);
      foreach (rows[r]) begin
         demod_lock_in = rows[r].demod;
         node_sync_in = rows[r].node;
         sym_count = rows[r].sym;
         dec_bit = rows[r].dbit;
         dec_bit_valid = rows[r].dval;
         @(negedge mclk);
         check(16'(demod_phase_locked), 16'(rows[r].demod));
         check(16'(decoder_node_synced), 16'(rows[r].node));
         check(16'(symbol_tick), 16'(rows[r].tick1));
         check(16'(raw_serial_clock), 16'(rows[r].rclk1));
         check(16'(overall_lock), 16'h0000);
         sym_count = 2'h0;
         dec_bit_valid = 1'b0;
         @(negedge mclk);
         check(16'(symbol_tick), 16'(rows[r].tick2));
         check(16'(u_sink.last_raw), 16'(rows[r].raw2));
      end
      ones_dac = 0;
      ones_agc = 0;
      repeat (256) begin
         @(negedge mclk);
         ones_dac += int'(aux_one_bit_dac);
         ones_agc += int'(gain_control_bitstream);
      end
      check(16'(ones_dac), 16'h0040);
      check(16'(ones_agc), 16'h00C0);
      prev = antenna_tone_out;
      for (k = 0; k < 600 && antenna_tone_out === prev; k++) @(negedge mclk);
      if (k == 600) timeout();
      prev = antenna_tone_out;
      for (k = 0; k < 600 && antenna_tone_out === prev; k++) @(negedge mclk);
      if (k == 600) timeout();
      check(16'(k), 16'(`TSO_TONE_HALF));
      test_ctrl = 8'h03;
      repeat (3) @(negedge mclk);
      check(test_out, 16'h0000);
      test_ctrl = 8'h00;
      demod_lock_in = 1'b1;
      node_sync_in = 1'b1;
      byte_sync_in = 1'b1;
      rs_sync_in = 1'b1;
      fork
         begin
            // Two bytes fill the buffer while the receiver stalls.
            push(8'h00, 1'b1);
            push(8'h01, 1'b0);
            check(16'(in_ready), 16'h0000);
            stall = 1'b0;
            for (i = 2; i < `TSO_BLOCK_LEN; i++) push(i[7:0], 1'b0);
            in_valid = 1'b0;
         end
         begin
            for (k = 0; k < 6000 && u_sink.n < 188; k++) @(negedge mclk);
            if (k == 6000) timeout();
            repeat (6) @(negedge mclk);
            prev = stream_clk;
            rises = 0;
            vals = 0;
            s0 = u_sink.strobes;
            repeat (120) begin
               @(negedge mclk);
               rises += int'(stream_clk && !prev);
               vals += int'(stream_valid);
               prev = stream_clk;
            end
            check(16'(rises), 16'h000F);
            check(16'(vals), 16'h0000);
            check(16'(u_sink.strobes - s0), 16'h0000);
         end
      join
      repeat (20) @(negedge mclk);
      check(16'(u_sink.n), 16'(`TSO_PAYLOAD_LEN));
      check(16'(u_sink.start_idx), 16'h0000);
      check(16'(u_sink.err_at_start), 16'h0001);
      check(16'(u_sink.strobes), 16'(`TSO_PAYLOAD_LEN));
      for (i = 0; i < 188; i++) begin
         check(16'(u_sink.got[i]), (i == 1) ? 16'h0081 : 16'(i));
      end
      check(16'(overall_lock), 16'h0001);
      // Serial passes capture on the falling edge, one per strobe style.
      cfg_edge_falling = 1'b1;
      format_ctrl = 8'h01;
      for (i = 0; i < 3; i++) begin
         test_ctrl = (i == 0) ? 8'h00 : (i == 1) ? 8'h20 : 8'h60;
         s0 = u_sink.strobes;
         vals = u_sink.n;
         push(8'hA5, 1'b1);
         push(8'h3C, 1'b0);
         in_valid = 1'b0;
         for (k = 0; k < 2000 && u_sink.n < vals + 16; k++) @(negedge mclk);
         if (k == 2000) timeout();
         repeat (16) @(negedge mclk);
         rises = 0;
         for (k = 0; k < 16; k++) begin
            rises = (rises << 1) | int'(u_sink.got[vals + k][0]);
         end
         check(16'(rises), 16'hA5BC);
         check(16'(u_sink.n - vals), 16'h0010);
         check(16'(u_sink.start_idx - vals), 16'h0007);
         k = (i == 0) ? 2 : (i == 1) ? 8 : 1;
         check(16'(u_sink.strobes - s0), 16'(k));
      end
      // Reset falls between rising edges to show it needs no clock.
      nrst = 1'b0;
      #1 check(16'(overall_lock), 16'h0000);
      check(16'(raw_serial_clock), 16'h0001);
      check(16'(stream_valid), 16'h0000);
      @(negedge mclk);
      nrst = 1'b1;
      test_ctrl = 8'h01;
      repeat (3) @(negedge mclk);
      check(test_out, {8'(`TSO_BLOCK_LEN - 1), 8'h06});
      print_verdict();
   end
endmodule
